// ===== pcc_consts.vh
// register offsets, field positions, reset values and timing counts
// of the voice codec control block; included by its design files.
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCC_ADDR_PATH_GAIN   8'h00
`define PCC_ADDR_SIDETONE    8'h01
`define PCC_ADDR_MUTE_POWER  8'h03
`define PCC_ADDR_LAW_PORT    8'h04
`define PCC_ADDR_STATUS      8'h06

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCC_TXG_LSB          0
`define PCC_RXG_LSB          3
`define PCC_STG_LSB          0
`define PCC_STEN_BIT         3
`define PCC_TXMUTE_BIT       0
`define PCC_RXMUTE_BIT       1
`define PCC_FDI_PD_BIT       2
`define PCC_DRV_PD_BIT       3
`define PCC_LAW_BIT          0
`define PCC_FMT_BIT          1
`define PCC_DEN_BIT          2
`define PCC_PORT_LSB         3
`define PCC_ST_OVR_BIT       0
`define PCC_ST_LAW_BIT       1
`define PCC_ST_MCLK_BIT      2

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define PCC_RST_PATH_GAIN    8'h00
`define PCC_RST_SIDETONE     8'h00
`define PCC_RST_MUTE_POWER   8'h00
`define PCC_RST_LAW_PORT     8'h00
`define PCC_PORT_STROBED     3'h0
`define PCC_PORT_TDM         3'h7
`define PCC_QUIET_SM         8'h00
`define PCC_MU_XOR           8'h7f
`define PCC_A_XOR            8'h55

// ----------------------------------------
// timing counts in link clock edges, b-channel number, master clock timeout in clk_sys cycles
// ----------------------------------------
`define PCC_SLOT_BITS        4'h8
`define PCC_FP_DELAY_HALF    9'h040
`define PCC_TDM_BCHAN        5'h02
`define PCC_MCLK_TIMEOUT     8'hff

`endif

// ===== pcc_code_map.v
// maps between the core's sign-magnitude byte and the line code.
// assumes purely combinational use; the map is its own inverse.
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_code_map (
   // selection
   input  wire       a_law,
   input  wire       sign_mag,
   // data
   input  wire [7:0] code_in,
   output reg  [7:0] code_out
);

   always @* begin
      if (sign_mag) begin
         code_out = code_in;
      end else if (a_law) begin
         code_out = code_in ^ `PCC_A_XOR;
      end else begin
         code_out = code_in ^ `PCC_MU_XOR;
      end
   end

endmodule // pcc_code_map

// ===== pcc_fifo.v
// small fifo with a registered output stage.
// assumes one clock and a synchronous, active high reset.
`timescale 1ns/1ps

module pcc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             rst,
   // filling side
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // draining side
   output reg  [WIDTH-1:0] out_data,
   output reg              out_valid,
   input  wire             out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            do_push;
   wire            do_pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign do_push  = in_valid && in_ready;
   assign do_pop   = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

   always @(posedge clk_sys) begin
      if (do_push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr    <= {AW{1'b0}};
         rd_ptr    <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         out_data  <= {WIDTH{1'b0}};
         out_valid <= 1'b0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            out_data  <= mem[rd_ptr];
            out_valid <= 1'b1;
            rd_ptr    <= rd_ptr + 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
         count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end

endmodule // pcc_fifo

// ===== pcc_top.v
// control and digital side of the voice codec: pcm link, registers,
// code mapping, quiet code and delayed strobe for cascading.
// assumes link pins are asynchronous to clk_sys, which runs far faster
// than the link clock; the register port is on clk_sys.
//
// Overview of operation
// - capture 8-bit data on falling link clock edges
// - emit 8-bit delayed strobe after strobe falls
// - tdm mode: frame pulse delayed four channels
// - reset: sidetone off, gains 0 dB, mu-law
// - reset: strobed mode, port and driver powered
// - three-bit transmit gain, 0 to +7 dB
// - three-bit receive gain, 0 to -7 dB
// - three-bit sidetone gain, 3.32 dB steps
// - sidetone bypasses transmit and receive gains
// - law is pin OR register bit
// - mu-law standard code assignment
// - a-law standard code assignment
// - sign-magnitude code assignment
// - format bit independent of law choice
// - law pin input while d-channel disabled
// - mute substitutes negative-zero quiet code
`timescale 1ns/1ps
`include "pcc_consts.vh"

module pcc_top (
   // clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // link pins
   input  wire       power_on_reset_n,
   input  wire       master_clock_in,
   input  wire       link_bit_clk,
   input  wire       slot_strobe_or_frame_in,
   input  wire       pcm_din,
   output reg        pcm_dout,
   output reg        pcm_dout_oe,
   output reg        delayed_strobe_out,
   input  wire       law_pin,
   // register port
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // transmit samples from the encoder, sign-magnitude
   input  wire [7:0] tx_sample,
   input  wire       tx_valid,
   output reg        tx_ready,
   // receive samples to the decoder, sign-magnitude
   output wire [7:0] rx_sample,
   output wire       rx_valid,
   input  wire       rx_ready,
   // settings toward the analog sections
   output reg  [2:0] tx_filter_gain,
   output reg  [2:0] rx_filter_gain,
   output reg  [2:0] sidetone_gain,
   output reg        sidetone_enable,
   output reg        law_a_select,
   output reg        code_format_select,
   output reg        fdi_power_on,
   output reg        driver_power_on
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam NSYNC = 6;
   wire [NSYNC-1:0] pins_raw;
   reg  [NSYNC-1:0] sync_a;
   reg  [NSYNC-1:0] sync_b;
   reg  [NSYNC-1:0] sync_c;

   assign pins_raw = {power_on_reset_n, master_clock_in, link_bit_clk,
                      slot_strobe_or_frame_in, pcm_din, law_pin};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge clk_sys) begin
            if (rst) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               sync_c[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= pins_raw[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   wire law_s   = sync_b[0];
   wire din_s   = sync_b[1];
   wire stb_s   = sync_b[2];
   wire stb_d   = sync_c[2];
   wire bclk_s  = sync_b[3];
   wire bclk_d  = sync_c[3];
   wire mclk_s  = sync_b[4];
   wire mclk_d  = sync_c[4];
   wire por_n_s = sync_b[5];

   wire bclk_rise = bclk_s && !bclk_d;
   wire bclk_fall = !bclk_s && bclk_d;
   wire stb_fall  = !stb_s && stb_d;
   wire mclk_edge = mclk_s != mclk_d;

   // a low power-on pin clears settings like the system reset
   wire cfg_rst = rst || !por_n_s;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg  [7:0] path_gain_settings;
   reg  [7:0] sidetone_settings;
   reg  [7:0] mute_power_settings;
   reg  [7:0] law_and_port_settings;
   reg        overrun;
   reg        mclk_seen;
   reg  [7:0] mclk_timer;
   wire       set_overrun;
   wire       law_a_eff;
   wire       fmt_sm;
   wire       tdm_mode;
   wire       tx_mute;
   wire       rx_mute;
   reg  [7:0] next_rdata;

   always @(posedge clk_sys) begin
      if (cfg_rst) begin
         path_gain_settings    <= `PCC_RST_PATH_GAIN;
         sidetone_settings     <= `PCC_RST_SIDETONE;
         mute_power_settings   <= `PCC_RST_MUTE_POWER;
         law_and_port_settings <= `PCC_RST_LAW_PORT;
      end else if (reg_wr) begin
         case (reg_addr)
            `PCC_ADDR_PATH_GAIN:  path_gain_settings    <= reg_wdata;
            `PCC_ADDR_SIDETONE:   sidetone_settings     <= reg_wdata;
            `PCC_ADDR_MUTE_POWER: mute_power_settings   <= reg_wdata;
            `PCC_ADDR_LAW_PORT:   law_and_port_settings <= reg_wdata;
            default: ;
         endcase
      end
   end

   // overrun: write one to clear, a new overrun in that cycle wins
   always @(posedge clk_sys) begin
      if (cfg_rst) begin
         overrun <= 1'b0;
      end else if (set_overrun) begin
         overrun <= 1'b1;
      end else if (reg_wr && reg_addr == `PCC_ADDR_STATUS && reg_wdata[`PCC_ST_OVR_BIT]) begin
         overrun <= 1'b0;
      end
   end

   // master clock presence; only a hint, the clock itself is analog side
   always @(posedge clk_sys) begin
      if (rst) begin
         mclk_timer <= 8'h00;
         mclk_seen  <= 1'b0;
      end else if (mclk_edge) begin
         mclk_timer <= `PCC_MCLK_TIMEOUT;
         mclk_seen  <= 1'b1;
      end else if (mclk_timer != 8'h00) begin
         mclk_timer <= mclk_timer - 8'h01;
      end else begin
         mclk_seen  <= 1'b0;
      end
   end

   // pin only counts as a law input while the d-channel is off
   assign law_a_eff = law_and_port_settings[`PCC_LAW_BIT] ||
                      (law_s && !law_and_port_settings[`PCC_DEN_BIT]);
   assign fmt_sm    = law_and_port_settings[`PCC_FMT_BIT];
   assign tdm_mode  = law_and_port_settings[`PCC_PORT_LSB+2:`PCC_PORT_LSB] == `PCC_PORT_TDM;
   assign tx_mute   = mute_power_settings[`PCC_TXMUTE_BIT];
   assign rx_mute   = mute_power_settings[`PCC_RXMUTE_BIT];

   always @* begin
      case (reg_addr)
         `PCC_ADDR_PATH_GAIN:  next_rdata = path_gain_settings;
         `PCC_ADDR_SIDETONE:   next_rdata = sidetone_settings;
         `PCC_ADDR_MUTE_POWER: next_rdata = mute_power_settings;
         `PCC_ADDR_LAW_PORT:   next_rdata = law_and_port_settings;
         `PCC_ADDR_STATUS:     next_rdata = {5'h00, mclk_seen, law_a_eff, overrun};
         default:              next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // analog settings: field code is the step count from 0 dB;
   // sidetone taps ahead of tx gain and sums after rx gain, so its
   // setting is carried apart from both path gains
   always @(posedge clk_sys) begin
      if (cfg_rst) begin
         tx_filter_gain     <= 3'h0;
         rx_filter_gain     <= 3'h0;
         sidetone_gain      <= 3'h0;
         sidetone_enable    <= 1'b0;
         law_a_select       <= 1'b0;
         code_format_select <= 1'b0;
         fdi_power_on       <= 1'b1;
         driver_power_on    <= 1'b1;
      end else begin
         tx_filter_gain     <= path_gain_settings[`PCC_TXG_LSB+2:`PCC_TXG_LSB];
         rx_filter_gain     <= path_gain_settings[`PCC_RXG_LSB+2:`PCC_RXG_LSB];
         sidetone_gain      <= sidetone_settings[`PCC_STG_LSB+2:`PCC_STG_LSB];
         sidetone_enable    <= sidetone_settings[`PCC_STEN_BIT];
         law_a_select       <= law_a_eff;
         code_format_select <= fmt_sm;
         fdi_power_on       <= !mute_power_settings[`PCC_FDI_PD_BIT];
         driver_power_on    <= !mute_power_settings[`PCC_DRV_PD_BIT];
      end
   end

   // ----------------------------------------
   // code mapping
   // ----------------------------------------
   reg  [7:0] tx_hold;
   reg        tx_full;
   reg        next_tx_full;
   wire [7:0] tx_sm;
   wire [7:0] tx_line;
   reg  [7:0] rx_shift;
   wire [7:0] rx_sm_raw;
   wire [7:0] rx_sm;

   assign tx_sm = (tx_mute || !tx_full) ? `PCC_QUIET_SM : tx_hold;

   pcc_code_map u_tx_map (
      .a_law    (law_a_eff),
      .sign_mag (fmt_sm),
      .code_in  (tx_sm),
      .code_out (tx_line)
   );

   pcc_code_map u_rx_map (
      .a_law    (law_a_eff),
      .sign_mag (fmt_sm),
      .code_in  (rx_shift),
      .code_out (rx_sm_raw)
   );

   assign rx_sm = rx_mute ? `PCC_QUIET_SM : rx_sm_raw;

   // ----------------------------------------
   // link timing
   // ----------------------------------------
   reg  [8:0] half_cnt;
   reg        frame_run;
   reg  [3:0] bit_cnt;
   reg  [7:0] tx_shift;
   reg        slot_on;
   reg        rx_push;
   reg        dstb_arm;
   reg  [3:0] dstb_cnt;
   wire       tdm_slot;
   wire       fp_start;
   wire       rx_in_ready;
   wire       slot_load;

   // tdm: frame begins with the pulse low on a falling link edge
   assign fp_start = tdm_mode && bclk_fall && !stb_s;
   assign tdm_slot = frame_run && (half_cnt[8:4] == `PCC_TDM_BCHAN);
   assign slot_load = tdm_mode ? (fp_start || (bclk_fall && half_cnt == 9'h01f))
                               : (bclk_rise && stb_s && !slot_on);
   assign set_overrun = rx_push && !rx_in_ready;

   always @(posedge clk_sys) begin
      if (rst) begin
         half_cnt  <= 9'h000;
         frame_run <= 1'b0;
      end else if (fp_start) begin
         half_cnt  <= 9'h000;
         frame_run <= 1'b1;
      end else if (bclk_fall && frame_run) begin
         half_cnt  <= half_cnt + 9'h001;
         if (half_cnt == 9'h1ff) begin
            frame_run <= 1'b0;
         end
      end
   end

   // transmit holding word, refilled after each slot load: once per strobed slot, twice per tdm frame
   always @* begin
      next_tx_full = tx_full;
      if (slot_load) begin
         next_tx_full = 1'b0;
      end
      if (tx_valid && tx_ready) begin
         next_tx_full = 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         tx_hold  <= 8'h00;
         tx_full  <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         if (tx_valid && tx_ready) begin
            tx_hold <= tx_sample;
         end
         tx_full  <= next_tx_full;
         tx_ready <= !next_tx_full && !(tx_valid && tx_ready);
      end
   end

   // serial data both ways, msb first
   always @(posedge clk_sys) begin
      if (rst) begin
         tx_shift    <= 8'h00;
         rx_shift    <= 8'h00;
         bit_cnt     <= 4'h0;
         slot_on     <= 1'b0;
         rx_push     <= 1'b0;
         pcm_dout    <= 1'b0;
         pcm_dout_oe <= 1'b0;
      end else begin
         rx_push <= 1'b0;
         if (slot_load) begin
            tx_shift <= tx_line;
            bit_cnt  <= 4'h0;
            slot_on  <= !tdm_mode;
         end
         if (!tdm_mode) begin
            // strobed mode: drive on rising, sample on falling edge
            if (bclk_rise && stb_s) begin
               pcm_dout    <= slot_load ? tx_line[7] : tx_shift[7];
               pcm_dout_oe <= 1'b1;
               // the loaded msb leaves now, so only the rest is kept
               tx_shift    <= slot_load ? {tx_line[6:0], 1'b0} : {tx_shift[6:0], 1'b0};
            end else if (bclk_rise) begin
               pcm_dout_oe <= 1'b0;
            end
            if (bclk_fall && stb_s && bit_cnt != `PCC_SLOT_BITS) begin
               rx_shift <= {rx_shift[6:0], din_s};
               bit_cnt  <= bit_cnt + 4'h1;
               if (bit_cnt == `PCC_SLOT_BITS - 4'h1) begin
                  rx_push <= 1'b1;
               end
            end
            if (stb_fall) begin
               slot_on <= 1'b0;
            end
         end else if (bclk_fall) begin
            // tdm: drive at cell start, sample at the later half
            if (tdm_slot && !half_cnt[0]) begin
               pcm_dout    <= tx_shift[7];
               pcm_dout_oe <= 1'b1;
               tx_shift    <= {tx_shift[6:0], 1'b0};
            end else if (!tdm_slot) begin
               pcm_dout_oe <= 1'b0;
            end
            if (tdm_slot && half_cnt[0]) begin
               rx_shift <= {rx_shift[6:0], din_s};
               if (half_cnt[3:1] == 3'h7) begin
                  rx_push <= 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // delayed strobe and frame pulse
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         dstb_arm           <= 1'b0;
         dstb_cnt           <= 4'h0;
         delayed_strobe_out <= 1'b0;
      end else if (tdm_mode) begin
         dstb_arm <= 1'b0;
         dstb_cnt <= 4'h0;
         // low going pulse one link clock wide, four channels late
         if (bclk_fall) begin
            delayed_strobe_out <= !(frame_run && half_cnt == `PCC_FP_DELAY_HALF - 9'h001);
         end
      end else begin
         if (stb_fall) begin
            dstb_arm <= 1'b1;
         end
         // eight bit cells wide, starting with the next rising edge
         if (bclk_rise && dstb_arm) begin
            dstb_arm           <= 1'b0;
            dstb_cnt           <= `PCC_SLOT_BITS;
            delayed_strobe_out <= 1'b1;
         end else if (bclk_rise && dstb_cnt != 4'h0) begin
            dstb_cnt <= dstb_cnt - 4'h1;
            if (dstb_cnt == 4'h1) begin
               delayed_strobe_out <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // receive buffer toward the decoder
   // ----------------------------------------
   // the link cannot be stalled, so a full buffer drops the byte and
   // flags overrun rather than corrupting the slot timing
   pcc_fifo #(
      .WIDTH (8),
      .DEPTH (4),
      .AW    (2)
   ) u_rx_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_data   (rx_sm),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .out_data  (rx_sample),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

endmodule // pcc_top

// ===== pcc_link_model.sv
// layer-1 transceiver on the strobed pcm link, behavioural.
// assumes the bench calls frame() or tdm_frame(); the clock runs at 80 ns.
`timescale 1ns/1ps
module pcc_link_model (
   // link pins
   output logic link_bit_clk,
   output logic slot_strobe_or_frame_in,
   output logic pcm_din,
   input  logic pcm_dout,
   input  logic delayed_strobe_out
);
   realtime t_next = 0;
   initial begin
      link_bit_clk = 1'b0;
      slot_strobe_or_frame_in = 1'b0;
      pcm_din = 1'b0;
   end
   // clock stands still between slots; ten trailing edges let the
   // delayed strobe run out
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      int i;
      if ($realtime < t_next) #(t_next - $realtime);
      t_next = $realtime + 125000.0;
      slot_strobe_or_frame_in = 1'b1;
      for (i = 0; i < 18; i++) begin
         if (i == 8) slot_strobe_or_frame_in = 1'b0;
         pcm_din = (i < 8) ? tx[7-i] : ~pcm_din;
         #20 link_bit_clk = 1'b1;
         #40 link_bit_clk = 1'b0;
         #20;
         if (i < 8) rx[7-i] = pcm_dout;
      end
   endtask
   // tdm: pulse low across the first falling edge; at returns the
   // falling edge after which the delayed pulse was first seen low
   task automatic tdm_frame(output int at);
      int i;
      at = -1;
      for (i = 0; i < 70; i++) begin
         slot_strobe_or_frame_in = (i == 0) ? 1'b0 : 1'b1;
         #20;
         if (i > 1 && !delayed_strobe_out && at < 0) at = i - 1;
         link_bit_clk = 1'b1;
         #40 link_bit_clk = 1'b0;
         #20;
      end
   endtask
endmodule // pcc_link_model

// ===== pcc_top_checker.sv
// port assertions for the codec control block.
// assumes a strobed link with an 80 ns bit clock.
`timescale 1ns/1ps
module pcc_top_checker (
   // clock and resets
   input logic       clk_sys,
   input logic       rst,
   input logic       power_on_reset_n,
   // pins and register port
   input logic       law_pin,
   input logic       slot_strobe_or_frame_in,
   input logic       pcm_dout_oe,
   input logic       delayed_strobe_out,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic       reg_wr,
   // settings
   input logic [2:0] tx_filter_gain,
   input logic [2:0] rx_filter_gain,
   input logic [2:0] sidetone_gain,
   input logic       sidetone_enable,
   input logic       law_a_select,
   input logic       code_format_select,
   input logic       fdi_power_on,
   input logic       driver_power_on
);
   logic [7:0] wd1, wd2, hi_cnt, lo_cnt, calm_cnt;
   logic       law_q, law_bit, den_bit, tdm_q;
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   always @(posedge clk_sys) begin
      wd1 <= reg_wdata;
      wd2 <= wd1;
      law_q <= law_pin;
      hi_cnt <= delayed_strobe_out ? hi_cnt + 8'h01 : 8'h00;
      lo_cnt <= (rst || slot_strobe_or_frame_in) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hc8};
      // pin passes a synchroniser, so only judge the law once settled
      calm_cnt <= (rst || reg_wr || !power_on_reset_n || law_pin != law_q) ? 8'h00
                  : calm_cnt + {7'h00, calm_cnt != 8'h08};
      if (rst || !power_on_reset_n) begin
         law_bit <= 1'b0;
         den_bit <= 1'b0;
         tdm_q   <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h04) begin
         law_bit <= reg_wdata[0];
         den_bit <= reg_wdata[2];
         tdm_q   <= reg_wdata[5:3] == 3'h7;
      end
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   chk_tx_gain_apply: assert property (reg_wr && reg_addr == 8'h00 |-> ##2 tx_filter_gain == wd2[2:0])
      else $error("tx gain not applied");
   chk_rx_gain_apply: assert property (reg_wr && reg_addr == 8'h00 |-> ##2 rx_filter_gain == wd2[5:3])
      else $error("rx gain not applied");
   chk_side_apply: assert property (reg_wr && reg_addr == 8'h01 |-> ##2 {sidetone_enable, sidetone_gain} == wd2[3:0])
      else $error("sidetone not applied");
   chk_side_isolated: assert property (reg_wr && reg_addr == 8'h00 |-> ##2 $stable({sidetone_enable, sidetone_gain}))
      else $error("sidetone moved by path gain");
   chk_fmt_apply: assert property (reg_wr && reg_addr == 8'h04 |-> ##2 code_format_select == wd2[1])
      else $error("format not applied");
   chk_law_or: assert property (calm_cnt == 8'h08 |-> law_a_select == (law_bit || (law_q && !den_bit)))
      else $error("law select wrong");
   chk_power_up: assert property ($fell(rst) |=> fdi_power_on && driver_power_on && tx_filter_gain == 3'h0 && !sidetone_enable)
      else $error("reset defaults wrong");
   chk_dstrobe_width: assert property (!tdm_q && $fell(delayed_strobe_out) |-> hi_cnt inside {[78:82]})
      else $error("delayed strobe width wrong");
   chk_fp_width: assert property (tdm_q && $fell(delayed_strobe_out) |->
      ##8 !delayed_strobe_out ##[1:3] delayed_strobe_out) else $error("delayed frame pulse width wrong");
   chk_oe_slot: assert property (lo_cnt == 8'h78 |-> !pcm_dout_oe)
      else $error("dout driven outside slot");
   cover property ($fell(delayed_strobe_out));
   cover property (calm_cnt == 8'h08 && law_a_select);
   cover property (reg_wr && reg_addr == 8'h01);
   cover property (tdm_q && $fell(delayed_strobe_out));
endmodule // pcc_top_checker
bind pcc_top pcc_top_checker pcc_top_checker_inst (.*);

// ===== test_pcc_top.sv
// self-checking bench: registers, law and format, link frames, rx fifo.
// assumes pcc_top, the link model and the checker are compiled.
`timescale 1ns/1ps
module test_pcc_top;
   logic       clk_sys = 1'b0, rst = 1'b1, power_on_reset_n = 1'b0, law_pin = 1'b0;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_sample = 8'h00;
   wire        master_clock_in, link_bit_clk, slot_strobe_or_frame_in, pcm_din, pcm_dout;
   wire        pcm_dout_oe, delayed_strobe_out, tx_ready, rx_valid, sidetone_enable;
   wire        law_a_select, code_format_select, fdi_power_on, driver_power_on;
   wire  [7:0] reg_rdata, rx_sample;
   wire  [2:0] tx_filter_gain, rx_filter_gain, sidetone_gain;
   int         num_errors = 0, comparisons = 0, seed = 32'he67bdc19, i, k;
   logic [7:0] g, s, ts, li, lo, cx;
   logic [7:0] rxq[$];

   always #4 clk_sys = ~clk_sys;
   assign master_clock_in = link_bit_clk;
   pcc_top pcc_top_inst (.*);
   pcc_link_model pcc_link_model_inst (.*);
   always @(posedge clk_sys)
      if (tx_valid && tx_ready) tx_valid <= #1 1'b0;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] got);
      comparisons++;
      if (got !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", w, e, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string w);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      chk(w, e, reg_rdata & m);
   endtask
   task automatic defaults;
      rd(8'h00, 8'h00, 8'hff, "path_gain");
      rd(8'h01, 8'h00, 8'hff, "sidetone");
      rd(8'h04, 8'h00, 8'hff, "law_port");
      chk("gains", 8'h00, {2'b00, tx_filter_gain, rx_filter_gain});
      chk("modes", 8'h03, {sidetone_gain, sidetone_enable, law_a_select, code_format_select,
          fdi_power_on, driver_power_on});
   endtask
   task final_report;
      if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #790000;
      num_errors++;
      final_report();
   end

   initial begin
      tick(20);
      rst = 1'b0;
      power_on_reset_n = 1'b1;
      tick(4);
      defaults();
      for (i = 0; i < 8; i++) begin
         s = 8'($random(seed)) & 8'h0f;
         g = {2'b00, 3'($random(seed)), 3'(i)};
         wr(8'h01, s);
         wr(8'h00, g);
         chk("tx_gain", {5'b0, g[2:0]}, {5'b0, tx_filter_gain});
         chk("rx_gain", {5'b0, g[5:3]}, {5'b0, rx_filter_gain});
         chk("st_gain", s, {4'b0, sidetone_enable, sidetone_gain});
         rd(8'h00, g, 8'hff, "path_gain_rd");
      end
      wr(8'h05, 8'h5a);
      rd(8'h05, 8'h00, 8'hff, "unmapped");
      wr(8'h04, 8'h03);
      power_on_reset_n = 1'b0;
      tick(6);
      power_on_reset_n = 1'b1;
      tick(6);
      defaults();
      for (i = 0; i < 8; i++) begin
         law_pin = i[0];
         wr(8'h04, {5'b0, i[2], 1'b0, i[1]});
         tick(6);
         chk("law", {7'b0, i[1] | (i[0] & ~i[2])}, {7'b0, law_a_select});
      end
      law_pin = 1'b0;
      // receive side stalled: five bytes fill the fifo, the sixth is lost
      for (i = 0; i < 6; i++) begin
         wr(8'h04, {6'b0, i[1], i[0]});
         wr(8'h03, {6'b0, i == 4, i == 5});
         cx = i[1] ? 8'h00 : (i[0] ? 8'h55 : 8'h7f);
         ts = 8'($random(seed));
         li = 8'($random(seed));
         tx_sample = ts;
         tx_valid = 1'b1;
         pcc_link_model_inst.frame(li, lo);
         chk("pcm_dout", (i == 5 ? 8'h00 : ts) ^ cx, lo);
         if (i < 5) rxq.push_back(i == 4 ? 8'h00 : li ^ cx);
      end
      rd(8'h06, 8'h07, 8'h07, "status");
      rx_ready = 1'b1;
      while (rxq.size() > 0) begin
         for (k = 0; k < 100 && rx_valid !== 1'b1; k++) tick(1);
         if (k == 100) begin
            num_errors++;
            final_report();
         end
         chk("rx_sample", rxq.pop_front(), rx_sample);
         tick(1);
      end
      tick(3);
      chk("rx_empty", 8'h00, {7'b0, rx_valid});
      wr(8'h06, 8'h01);
      rd(8'h06, 8'h00, 8'h01, "overrun_clr");
      // tdm: delayed pulse four channels of eight two-half bits late
      wr(8'h04, 8'h38);
      pcc_link_model_inst.tdm_frame(k);
      chk("fp_delay", 8'(4 * 8 * 2), 8'(k));
      final_report();
   end
endmodule // test_pcc_top
